// ===== rtl/rfsc_consts.vh
// Register offsets, field positions, reset values and timing counts
`ifndef RFSC_CONSTS_VH
`define RFSC_CONSTS_VH

// ========================================
// Register offsets (6-bit configuration address)
`define RFSC_ADDR_TRIM_A 6'h20
`define RFSC_ADDR_RX_FE 6'h21
`define RFSC_ADDR_TX_FE 6'h22
`define RFSC_ADDR_PUMP_CFG 6'h23
`define RFSC_ADDR_OSC_CUR 6'h24
`define RFSC_ADDR_COARSE 6'h25
`define RFSC_ADDR_CAL_CTRL 6'h26
`define RFSC_ADDR_TRIM_B 6'h29
`define RFSC_ADDR_TRIM_C 6'h2A
`define RFSC_ADDR_TRIM_D 6'h2B
`define RFSC_ADDR_TEST_TWO 6'h2C
`define RFSC_ADDR_PWR_TAB0 6'h3C
`define RFSC_ADDR_PWR_TAB1 6'h3D

// ========================================
// Reset and wake values
`define RFSC_RST_TRIM_A 8'hF8
`define RFSC_RST_RX_FE 8'h56
`define RFSC_RST_TX_FE 8'h10
`define RFSC_RST_PUMP_CFG 8'hA9
`define RFSC_RST_OSC_CUR 8'h0A
`define RFSC_RST_COARSE 8'h20
`define RFSC_RST_CAL_CTRL 8'h0D
`define RFSC_RST_TRIM_B 8'h59
`define RFSC_RST_TRIM_C 8'h7F
`define RFSC_RST_TRIM_D 8'h3F
`define RFSC_RST_TEST_TWO 8'h88
`define RFSC_WAKE_TEST_TWO_RET 8'h81
`define RFSC_RST_PWR_TAB 8'h00

// ========================================
// Implemented-bit masks
`define RFSC_MASK_TRIM_A 8'hFB
`define RFSC_MASK_TX_FE 8'h37
`define RFSC_MASK_OSC_CUR 8'h3F
`define RFSC_MASK_COARSE 8'h3F
`define RFSC_MASK_CAL_CTRL 8'h7F
`define RFSC_MASK_FULL 8'hFF

// ========================================
// Field positions
`define RFSC_PWR_IDX_MSB 2
`define RFSC_PWR_IDX_LSB 0
`define RFSC_PUMP_EN_MSB 5
`define RFSC_PUMP_EN_LSB 4
`define RFSC_PUMP_RES_MSB 3
`define RFSC_PUMP_RES_LSB 0
`define RFSC_CORE_HI_BIT 5
`define RFSC_OSC_RES_MSB 4
`define RFSC_OSC_RES_LSB 0
`define RFSC_COARSE_MSB 5
`define RFSC_COARSE_LSB 0

// ========================================
// Timing: each calibration stage settles for a least time
`define RFSC_CLK_PERIOD_NS 8
`define RFSC_STAGE_TIME_NS 40
`define RFSC_STAGE_CYCLES \
  ((`RFSC_STAGE_TIME_NS + `RFSC_CLK_PERIOD_NS - 1) / `RFSC_CLK_PERIOD_NS)

`endif

// ===== rtl/rfsc_power_table.v
// Two-entry output power table with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "rfsc_consts.vh"

module rfsc_power_table (
  input wire core_clk,
  input wire rst,
  input wire wr_en,
  input wire wr_index,
  input wire [7:0] wr_data,
  input wire [2:0] rd_index,
  output reg [7:0] rd_data,
  output reg [7:0] setting
);

  reg [7:0] entry_reg [0:1];

  // Indices above one select no entry and give zero power
  always @(posedge core_clk) begin
    if (rst) begin
      entry_reg[0] <= `RFSC_RST_PWR_TAB;
      entry_reg[1] <= `RFSC_RST_PWR_TAB;
      setting <= `RFSC_RST_PWR_TAB;
      rd_data <= 8'h00;
    end else begin
      if (wr_en) begin
        entry_reg[wr_index] <= wr_data;
      end
      if (rd_index[2:1] == 2'h0) begin
        setting <= entry_reg[rd_index[0]];
      end else begin
        setting <= 8'h00;
      end
      rd_data <= entry_reg[wr_index];
    end
  end

endmodule

`default_nettype wire

// ===== rtl/rfsc_regs.v
// Front-end and synthesizer calibration register bank
`timescale 1ns/10ps
`default_nettype none
`include "rfsc_consts.vh"

module rfsc_regs (
  input wire core_clk,
  input wire rst,
  input wire [5:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire converter_retention_bit,
  input wire sleep_active,
  input wire cal_start,
  input wire [3:0] pump_cal_result,
  input wire [4:0] osc_cal_result,
  input wire [5:0] coarse_cal_result,
  output wire cal_busy,
  output reg cal_done,
  output wire pump_cal_active,
  output wire osc_cal_active,
  output wire coarse_cal_active,
  output wire [7:0] pa_setting,
  output wire osc_core_high_select,
  output wire [7:0] rx_frontend_current_config,
  output wire [1:0] tx_lo_buf_current,
  output wire [3:0] pump_current_trim,
  output wire [4:0] osc_current_trim,
  output wire [5:0] coarse_tune_trim,
  output wire [6:0] cal_control,
  output wire [7:0] trim_a,
  output wire [7:0] trim_b,
  output wire [7:0] trim_c,
  output wire [7:0] trim_d,
  output wire [7:0] test_two_internal
);

  // ========================================
  // Helpers
  function [7:0] masked;
    input [7:0] value;
    input [7:0] mask;
    begin
      masked = value & mask;
    end
  endfunction

  function hit;
    input [5:0] addr;
    input [5:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // ========================================
  // Calibration sequencer states
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_PUMP = 5'h02;
  localparam [4:0] ST_OSC = 5'h04;
  localparam [4:0] ST_COARSE = 5'h08;
  localparam [4:0] ST_DONE = 5'h10;
  localparam integer STAGE_CYC_INT = `RFSC_STAGE_CYCLES;
  localparam [7:0] STAGE_CYC = STAGE_CYC_INT[7:0];

  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [7:0] stage_cnt_reg;
  reg [7:0] trim_a_reg;
  reg [7:0] rx_fe_reg;
  reg [7:0] tx_fe_reg;
  reg [7:0] pump_cfg_reg;
  reg [7:0] osc_cur_reg;
  reg [7:0] coarse_reg;
  reg [7:0] cal_ctrl_reg;
  reg [7:0] trim_b_reg;
  reg [7:0] trim_c_reg;
  reg [7:0] trim_d_reg;
  reg [7:0] test_two_reg;
  reg test_two_forced_reg;
  reg test_two_ret_reg;
  reg sleep_prev_reg;

  wire stage_end = (stage_cnt_reg == STAGE_CYC - 8'h01);
  wire wake = sleep_prev_reg & ~sleep_active;
  // Host writes into the volatile group are dropped while asleep
  wire wr_awake = reg_wr & ~sleep_active;
  wire tab_wr = reg_wr & (hit(reg_addr, `RFSC_ADDR_PWR_TAB0) |
    hit(reg_addr, `RFSC_ADDR_PWR_TAB1));
  wire [7:0] tab_rdata;

  // ========================================
  // Sequencer
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cal_start) begin
          if (pump_cfg_reg[`RFSC_PUMP_EN_MSB:`RFSC_PUMP_EN_LSB] == 2'h0) begin
            state_next = ST_OSC;
          end else begin
            state_next = ST_PUMP;
          end
        end
      end
      ST_PUMP: begin
        if (stage_end) begin
          state_next = ST_OSC;
        end
      end
      ST_OSC: begin
        if (stage_end) begin
          state_next = ST_COARSE;
        end
      end
      ST_COARSE: begin
        if (stage_end) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      stage_cnt_reg <= 8'h00;
      cal_done <= 1'b0;
    end else begin
      state_reg <= state_next;
      cal_done <= (state_reg == ST_DONE);
      if (state_next != state_reg) begin
        stage_cnt_reg <= 8'h00;
      end else if (state_reg != ST_IDLE) begin
        stage_cnt_reg <= stage_cnt_reg + 8'h01;
      end
    end
  end

  // ========================================
  // Retained configuration; a stage result beats a host write in one cycle
  always @(posedge core_clk) begin
    if (rst) begin
      trim_a_reg <= `RFSC_RST_TRIM_A;
      rx_fe_reg <= `RFSC_RST_RX_FE;
      tx_fe_reg <= `RFSC_RST_TX_FE;
      pump_cfg_reg <= `RFSC_RST_PUMP_CFG;
      osc_cur_reg <= `RFSC_RST_OSC_CUR;
      coarse_reg <= `RFSC_RST_COARSE;
      cal_ctrl_reg <= `RFSC_RST_CAL_CTRL;
    end else begin
      if (reg_wr) begin
        if (hit(reg_addr, `RFSC_ADDR_TRIM_A))
          trim_a_reg <= masked(reg_wdata, `RFSC_MASK_TRIM_A);
        if (hit(reg_addr, `RFSC_ADDR_RX_FE))
          rx_fe_reg <= reg_wdata;
        if (hit(reg_addr, `RFSC_ADDR_TX_FE))
          tx_fe_reg <= masked(reg_wdata, `RFSC_MASK_TX_FE);
        if (hit(reg_addr, `RFSC_ADDR_PUMP_CFG))
          pump_cfg_reg <= reg_wdata;
        if (hit(reg_addr, `RFSC_ADDR_OSC_CUR))
          osc_cur_reg <= masked(reg_wdata, `RFSC_MASK_OSC_CUR);
        if (hit(reg_addr, `RFSC_ADDR_COARSE))
          coarse_reg <= masked(reg_wdata, `RFSC_MASK_COARSE);
        if (hit(reg_addr, `RFSC_ADDR_CAL_CTRL))
          cal_ctrl_reg <= masked(reg_wdata, `RFSC_MASK_CAL_CTRL);
      end
      if (pump_cal_active & stage_end)
        pump_cfg_reg[`RFSC_PUMP_RES_MSB:`RFSC_PUMP_RES_LSB] <=
          pump_cal_result;
      if (osc_cal_active & stage_end)
        osc_cur_reg[`RFSC_OSC_RES_MSB:`RFSC_OSC_RES_LSB] <=
          osc_cal_result;
      if (coarse_cal_active & stage_end)
        coarse_reg[`RFSC_COARSE_MSB:`RFSC_COARSE_LSB] <=
          coarse_cal_result;
    end
  end

  // ========================================
  // Volatile test group, restored to defaults on wake
  always @(posedge core_clk) begin
    if (rst) begin
      sleep_prev_reg <= 1'b0;
      trim_b_reg <= `RFSC_RST_TRIM_B;
      trim_c_reg <= `RFSC_RST_TRIM_C;
      trim_d_reg <= `RFSC_RST_TRIM_D;
      test_two_reg <= `RFSC_RST_TEST_TWO;
      test_two_forced_reg <= 1'b0;
      test_two_ret_reg <= 1'b0;
    end else begin
      sleep_prev_reg <= sleep_active;
      if (wake) begin
        trim_b_reg <= `RFSC_RST_TRIM_B;
        trim_c_reg <= `RFSC_RST_TRIM_C;
        trim_d_reg <= `RFSC_RST_TRIM_D;
        test_two_reg <= `RFSC_RST_TEST_TWO;
        test_two_forced_reg <= 1'b1;
        test_two_ret_reg <= converter_retention_bit;
      end else if (wr_awake) begin
        if (hit(reg_addr, `RFSC_ADDR_TRIM_B))
          trim_b_reg <= reg_wdata;
        if (hit(reg_addr, `RFSC_ADDR_TRIM_C))
          trim_c_reg <= reg_wdata;
        if (hit(reg_addr, `RFSC_ADDR_TRIM_D))
          trim_d_reg <= reg_wdata;
        if (hit(reg_addr, `RFSC_ADDR_TEST_TWO)) begin
          test_two_reg <= reg_wdata;
          test_two_forced_reg <= 1'b0;
        end
      end
    end
  end

  // ========================================
  // Read port, one cycle latency
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `RFSC_ADDR_TRIM_A: reg_rdata <= trim_a_reg;
        `RFSC_ADDR_RX_FE: reg_rdata <= rx_fe_reg;
        `RFSC_ADDR_TX_FE: reg_rdata <= tx_fe_reg;
        `RFSC_ADDR_PUMP_CFG: reg_rdata <= pump_cfg_reg;
        `RFSC_ADDR_OSC_CUR: reg_rdata <= osc_cur_reg;
        `RFSC_ADDR_COARSE: reg_rdata <= coarse_reg;
        `RFSC_ADDR_CAL_CTRL: reg_rdata <= cal_ctrl_reg;
        `RFSC_ADDR_TRIM_B: reg_rdata <= trim_b_reg;
        `RFSC_ADDR_TRIM_C: reg_rdata <= trim_c_reg;
        `RFSC_ADDR_TRIM_D: reg_rdata <= trim_d_reg;
        `RFSC_ADDR_TEST_TWO: reg_rdata <= test_two_reg;
        `RFSC_ADDR_PWR_TAB0: reg_rdata <= tab_rdata;
        `RFSC_ADDR_PWR_TAB1: reg_rdata <= tab_rdata;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Table read data follows the address one cycle late, so a table read
  // must hold its address for two cycles
  rfsc_power_table u_power_table (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(tab_wr),
    .wr_index(reg_addr[0]),
    .wr_data(reg_wdata),
    .rd_index(tx_fe_reg[`RFSC_PWR_IDX_MSB:`RFSC_PWR_IDX_LSB]),
    .rd_data(tab_rdata),
    .setting(pa_setting)
  );

  // ========================================
  // Outputs
  assign cal_busy = (state_reg != ST_IDLE);
  assign pump_cal_active = (state_reg == ST_PUMP);
  assign osc_cal_active = (state_reg == ST_OSC);
  assign coarse_cal_active = (state_reg == ST_COARSE);
  assign osc_core_high_select = osc_cur_reg[`RFSC_CORE_HI_BIT];
  assign rx_frontend_current_config = rx_fe_reg;
  assign tx_lo_buf_current = tx_fe_reg[5:4];
  assign pump_current_trim = pump_cfg_reg[3:0];
  assign osc_current_trim = osc_cur_reg[4:0];
  assign coarse_tune_trim = coarse_reg[5:0];
  assign cal_control = cal_ctrl_reg[6:0];
  assign trim_a = trim_a_reg;
  assign trim_b = trim_b_reg;
  assign trim_c = trim_c_reg;
  assign trim_d = trim_d_reg;
  // Only the analogue side sees the retention-altered value
  assign test_two_internal = (test_two_forced_reg & test_two_ret_reg) ?
    `RFSC_WAKE_TEST_TWO_RET : test_two_reg;

endmodule

`default_nettype wire

// ===== testbench/rfsc_host.sv
// Host model driving the parallel register strobe port
`timescale 1ns/10ps
`default_nettype none
module rfsc_host (
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata,
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Lines flip once released, so off-strobe sampling shows up
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge core_clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge core_clk);
    {reg_addr, reg_rd} = {~a, 1'b0};
    d = reg_rdata;
  endtask
  // Table read data are registered, so the address leads the strobe
  task automatic rd_tab(input logic [5:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b1;
    @(negedge core_clk);
    {reg_addr, reg_rd} = {~a, 1'b0};
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ===== testbench/rfsc_regs_chk.sv
// Port assertions for the register bank
`timescale 1ns/10ps
`default_nettype none
module rfsc_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic converter_retention_bit,
  input wire logic sleep_active,
  input wire logic cal_start,
  input wire logic cal_busy,
  input wire logic cal_done,
  input wire logic pump_cal_active,
  input wire logic osc_cal_active,
  input wire logic coarse_cal_active,
  input wire logic [3:0] pump_cal_result,
  input wire logic osc_core_high_select,
  input wire logic [3:0] pump_current_trim,
  input wire logic [4:0] osc_current_trim,
  input wire logic [5:0] coarse_tune_trim,
  input wire logic [7:0] trim_b,
  input wire logic [7:0] trim_c,
  input wire logic [7:0] trim_d,
  input wire logic [7:0] test_two_internal
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Set from wake until the host rewrites test-two while awake
  logic t2_clean;
  always @(posedge core_clk) begin
    if (rst)
      t2_clean <= 1'b0;
    else if ($fell(sleep_active))
      t2_clean <= 1'b1;
    else if (reg_wr && !sleep_active && reg_addr == 6'h2C)
      t2_clean <= 1'b0;
  end
  // ========================================
  // Sequences
  sequence s_go;
    cal_start && !cal_busy;
  endsequence
  sequence s_tail;
    osc_cal_active [*5] ##1 coarse_cal_active [*5] ##2 cal_done;
  endsequence
  sequence s_wake;
    $fell(sleep_active);
  endsequence
  sequence s_wr(logic [5:0] a);
    reg_wr && reg_addr == a && !cal_busy;
  endsequence
  // ========================================
  // Properties
  property p_unm;
    reg_rd && reg_addr == 6'h27 |=> reg_rdata == 8'h00;
  endproperty
  property p_core;
    s_wr(6'h24) |=> osc_core_high_select == $past(reg_wdata[5]);
  endproperty
  property p_osc;
    s_wr(6'h24) |=> osc_current_trim == $past(reg_wdata[4:0]);
  endproperty
  property p_coarse;
    s_wr(6'h25) |=> coarse_tune_trim == $past(reg_wdata[5:0]);
  endproperty
  property p_pump;
    $fell(pump_cal_active) |-> pump_current_trim == $past(pump_cal_result);
  endproperty
  property p_cal_on;
    s_go ##1 pump_cal_active |-> pump_cal_active [*5] ##1 s_tail;
  endproperty
  property p_cal_off;
    s_go ##1 !pump_cal_active |-> s_tail;
  endproperty
  property p_wake;
    s_wake |=> test_two_internal ==
      ($past(converter_retention_bit) ? 8'h81 : 8'h88);
  endproperty
  property p_t2rd;
    reg_rd && reg_addr == 6'h2C && t2_clean |=> reg_rdata == 8'h88;
  endproperty
  property p_lost;
    s_wake |=> trim_b == 8'h59 && trim_c == 8'h7F && trim_d == 8'h3F;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  a_core: assert property (p_core) else $error("core select");
  a_osc: assert property (p_osc) else $error("osc override");
  a_coarse: assert property (p_coarse) else $error("coarse");
  a_pump: assert property (p_pump) else $error("pump result");
  a_cal_on: assert property (p_cal_on) else $error("cal on");
  a_cal_off: assert property (p_cal_off) else $error("cal off");
  a_wake: assert property (p_wake) else $error("wake value");
  a_t2rd: assert property (p_t2rd) else $error("test two read");
  a_lost: assert property (p_lost) else $error("sleep loss");
endmodule
bind rfsc_regs rfsc_chk u_chk (.*);
`default_nettype wire

// ===== testbench/rfsc_regs_tb.sv
// Self-checking bench for the front-end and calibration register bank
`timescale 1ns/10ps
`default_nettype none
module rfsc_regs_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic converter_retention_bit = 1'b0;
  logic sleep_active = 1'b0;
  logic cal_start = 1'b0;
  logic [3:0] pump_cal_result = 4'h0;
  logic [4:0] osc_cal_result = 5'h00;
  logic [5:0] coarse_cal_result = 6'h00;
  wire [5:0] reg_addr;
  wire [7:0] reg_wdata, reg_rdata, pa_setting, rx_frontend_current_config;
  wire [7:0] trim_a, trim_b, trim_c, trim_d, test_two_internal;
  wire reg_wr, reg_rd, cal_busy, cal_done, osc_core_high_select;
  wire pump_cal_active, osc_cal_active, coarse_cal_active;
  wire [1:0] tx_lo_buf_current;
  wire [3:0] pump_current_trim;
  wire [4:0] osc_current_trim;
  wire [5:0] coarse_tune_trim;
  wire [6:0] cal_control;
  int miscompares = 0;
  int n_checks = 0;
  logic [7:0] d, v, p0, p1;
  rfsc_regs dut (.*);
  rfsc_host host (.*);
  always #4 core_clk = ~core_clk;
  // ========================================
  // Checking and expectations
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] rst_val(input logic [5:0] a);
    case (a)
      6'h20: return 8'hF8;
      6'h21: return 8'h56;
      6'h22: return 8'h10;
      6'h23: return 8'hA9;
      6'h24: return 8'h0A;
      6'h25: return 8'h20;
      6'h26: return 8'h0D;
      6'h29: return 8'h59;
      6'h2A: return 8'h7F;
      6'h2B: return 8'h3F;
      6'h2C: return 8'h88;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] mask(input logic [5:0] a);
    case (a)
      6'h20: return 8'hFB;
      6'h22: return 8'h37;
      6'h24, 6'h25: return 8'h3F;
      6'h26: return 8'h7F;
      6'h21, 6'h23, 6'h29, 6'h2A, 6'h2B, 6'h2C: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction
  // Results are drawn once per call and stay fixed for the whole calibration, so any stage sample is valid
  task automatic cal(input logic [1:0] en);
    int i;
    host.wr(6'h24, 8'h20);
    host.wr(6'h23, {2'b10, en, 4'h9});
    pump_cal_result = 4'($urandom);
    osc_cal_result = 5'($urandom);
    coarse_cal_result = 6'($urandom);
    cal_start = 1'b1;
    @(negedge core_clk);
    cal_start = 1'b0;
    @(negedge core_clk);
    cal_start = 1'b1;
    @(negedge core_clk);
    cal_start = 1'b0;
    for (i = 0; i < 40 && cal_done !== 1'b1; i++) @(negedge core_clk);
    if (i == 40) begin
      miscompares++;
      stop_test();
    end
    host.rd(6'h23, d);
    chk(d, {2'b10, en, (en != 2'b00) ? pump_cal_result : 4'h9});
    host.rd(6'h24, d);
    chk(d, {3'b001, osc_cal_result});
    host.rd(6'h25, d);
    chk(d, {2'b00, coarse_cal_result});
  endtask
  // ========================================
  // Main sequence
  initial begin
    int i;
    int k;
    void'($urandom(35));
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    for (i = 6'h20; i <= 6'h2C; i++) begin
      host.rd(6'(i), d);
      chk(d, rst_val(6'(i)));
    end
    for (k = 0; k < 2; k++) begin
      for (i = 6'h20; i <= 6'h2C; i++) begin
        v = (k != 0) ? 8'($urandom) : 8'hFF;
        host.wr(6'(i), v);
        host.rd(6'(i), d);
        chk(d, v & mask(6'(i)));
        case (i)
          6'h20: chk(trim_a, v & 8'hFB);
          6'h21: chk(rx_frontend_current_config, v);
          6'h22: chk({6'h00, tx_lo_buf_current}, {6'h00, v[5:4]});
          6'h26: chk({1'b0, cal_control}, v & 8'h7F);
          6'h2A: chk(trim_c, v);
          6'h2B: chk(trim_d, v);
          default: ;
        endcase
      end
    end
    p0 = 8'($urandom);
    p1 = 8'($urandom);
    host.wr(6'h3C, p0);
    host.wr(6'h3D, p1);
    host.rd_tab(6'h3C, d);
    chk(d, p0);
    host.rd_tab(6'h3D, d);
    chk(d, p1);
    for (i = 0; i < 8; i++) begin
      host.wr(6'h22, {5'b00010, 3'(i)});
      @(negedge core_clk);
      chk(pa_setting, (i == 0) ? p0 : (i == 1) ? p1 : 8'h00);
    end
    cal(2'b10);
    cal(2'b00);
    for (k = 0; k < 2; k++) begin
      host.wr(6'h29, 8'hA5);
      host.wr(6'h2C, 8'h00);
      converter_retention_bit = k[0];
      sleep_active = 1'b1;
      repeat (4) @(negedge core_clk);
      sleep_active = 1'b0;
      @(negedge core_clk);
      chk(trim_b, 8'h59);
      chk(test_two_internal, (k != 0) ? 8'h81 : 8'h88);
      host.rd(6'h2C, d);
      chk(d, 8'h88);
      host.wr(6'h29, 8'h5A);
      chk(trim_b, 8'h5A);
    end
    stop_test();
  end
endmodule
`default_nettype wire
